// ===== dv/plc_led_model.sv
// led model timing the blue element
`timescale 1ns/1ps
module plc_led_model (
  input wire logic clk_sys_in,
  input wire logic red_in,
  input wire logic green_in,
  input wire logic blue_in,
  output logic [31:0] per_out,
  output logic [31:0] high_out,
  output logic [31:0] lit_out
);
  logic [31:0] cyc = 0;
  logic [31:0] rise = 0;
  logic b_q = 0;
  initial {per_out, high_out, lit_out} = '0;
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    b_q <= blue_in;
    lit_out <= lit_out + {31'h0, red_in | green_in};
    if (blue_in && !b_q) begin
      per_out <= cyc - rise;
      rise <= cyc;
    end
    if (!blue_in && b_q) high_out <= cyc - rise;
  end
endmodule

// ===== dv/plc_top_bench.sv
// bench for the led modulator
`timescale 1ns/1ps
module plc_top_bench;
  logic clk_sys_in = 0, reset_in = 1, mode = 0, dflt = 0, r, g, b;
  logic [15:0] per = 16'h3, cmp = 16'h1, c;
  logic [2:0] idx;
  logic [31:0] mp, mh, lit;
  int err_total = 0, samples_checked = 0, cycles = 0;
  plc_top plc_top_inst (.clk_sys_in, .reset_in, .mode_colour_in(mode), .blink_period_in(per),
    .blink_compare_in(cmp), .use_defaults_in(dflt), .red_led_drive_out(r),
    .green_led_drive_out(g), .blue_led_drive_out(b), .colour_index_out(idx));
  plc_led_model plc_led_model_inst (.clk_sys_in, .red_in(r), .green_in(g), .blue_in(b),
    .per_out(mp), .high_out(mh), .lit_out(lit));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  // ceiling just above the four tests plus their resets
  always @(posedge clk_sys_in) if (++cycles == 99000) begin err_total++; give_verdict(); end
  function automatic logic [31:0] ticks(input logic [15:0] n);
    return n * plc_pkg::COUNT_DIV;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic run(input logic m, d, input logic [15:0] cm, input int n);
    @(posedge clk_sys_in);
    #1 reset_in = 1;
    {mode, dflt, cmp} = {m, d, cm};
    repeat (2) @(posedge clk_sys_in);
    #1 reset_in = 0;
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  initial begin
    void'($urandom(16663));
    c = 16'h1 + 16'($urandom % 2);
    repeat (4) @(posedge clk_sys_in);
    // two rising edges are needed even when compare 1 delays the first one to tick 3
    run(0, 0, c, 62000);
    chk(mp, ticks(per));
    chk(mh, ticks(c));
    $display("test period done");
    run(0, 1, c, 11000);
    chk(b, 1);
    $display("test defaults done");
    run(0, 0, 16'h0, 11000);
    chk(b, 0);
    chk(lit, 0);
    $display("test zero done");
    run(1, 0, c, 11000);
    chk(idx, 0);
    chk(r, 1);
    chk(g, 0);
    $display("test colour done");
    give_verdict();
  end
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule

// ===== dv/plc_top_sva.sv
// checker on the led drive ports
`timescale 1ns/1ps
module plc_top_sva (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic mode_colour_in,
  input wire logic [15:0] blink_compare_in,
  input wire logic use_defaults_in,
  input wire logic red_led_drive_out,
  input wire logic green_led_drive_out,
  input wire logic blue_led_drive_out,
  input wire logic [2:0] colour_index_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ====
  // cycles with compare zero; one tick plus slack
  logic [13:0] zc_q;
  wire zc_d = !mode_colour_in && !use_defaults_in && blink_compare_in == 16'h0;
  always_ff @(posedge clk_sys_in) zc_q <= (reset_in || !zc_d) ? 14'h0 : zc_q + 14'h1;
  property p_red; !mode_colour_in[*2] |=> !red_led_drive_out; endproperty
  a_red: assert property (p_red) else $error("red lit");
  property p_grn; !mode_colour_in[*2] |=> !green_led_drive_out; endproperty
  a_grn: assert property (p_grn) else $error("green lit");
  property p_hold; $changed(blue_led_drive_out) |=> $stable(blue_led_drive_out)[*8]; endproperty
  a_hold: assert property (p_hold) else $error("blue off tick");
  property p_zero; zc_q > 14'h2720 |-> !blue_led_drive_out; endproperty
  a_zero: assert property (p_zero) else $error("blue lit at zero");
  property p_max; colour_index_out <= 3'h6; endproperty
  a_max: assert property (p_max) else $error("index range");
  property p_ihold; $changed(colour_index_out) |=> $stable(colour_index_out)[*8]; endproperty
  a_ihold: assert property (p_ihold) else $error("index hold");
  property p_step; $changed(colour_index_out) |->
    colour_index_out == $past(colour_index_out) + 3'h1 || colour_index_out == 3'h0; endproperty
  a_step: assert property (p_step) else $error("index order");
  property p_rst; disable iff (1'b0) reset_in |=> !red_led_drive_out && !green_led_drive_out
    && !blue_led_drive_out && colour_index_out == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  c_blue: cover property ($rose(blue_led_drive_out));
  c_zero: cover property (zc_q == 14'h2721);
  c_col: cover property (mode_colour_in[*8]);
endmodule
bind plc_top plc_top_sva plc_top_sva_inst (.clk_sys_in, .reset_in, .mode_colour_in,
  .blink_compare_in, .use_defaults_in, .red_led_drive_out, .green_led_drive_out,
  .blue_led_drive_out, .colour_index_out);

// ===== logic/plc_channel.sv
// one left-aligned pulse-width channel with 16-bit period and compare
`timescale 1ns/1ps
module plc_channel (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic tick_in,
  input wire logic [plc_pkg::CNT_W-1:0] period_in,
  input wire logic [plc_pkg::CNT_W-1:0] compare_in,
  output logic pwm_out
);
  logic [plc_pkg::CNT_W-1:0] count_q;
  logic [plc_pkg::CNT_W-1:0] count_d;
  logic pwm_q;
  wire logic at_top = (count_q >= period_in);
  // ==========================================================================
  // counter advances only on the counting enable, wraps after period
  assign count_d = at_top ? '0 : count_q + 16'h0001; // see R8
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      count_q <= '0;
      pwm_q <= 1'b0;
    end else if (tick_in) begin
      count_q <= count_d; // see R4
      pwm_q <= (count_d < compare_in); // see R8 see R3
    end
  end
  assign pwm_out = pwm_q;
endmodule

// ===== logic/plc_pkg.sv
// constants for the led pulse-width modulator and colour cycle
//
// Notes on behaviour
// R1 - single-channel setup drives the blue led element from the modulator output
// R2 - default single channel blinks at 1 Hz with 50 percent duty
// R3 - period value sets frequency; compare value sets duty independently
// R4 - counter advances on a 10 kHz counting clock enable
// R5 - colour setup drives red, green and blue from three independent channels
// R6 - seven colours, violet through red, each held one second
// R7 - colours change only compare values; periods stay fixed
// R8 - count 0..period then wrap; output high while count below compare; 16-bit fields
package plc_pkg;
  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned COUNT_HZ = 10000;
  localparam int unsigned COUNT_DIV = CLK_HZ / COUNT_HZ;
  localparam int unsigned DIV_W = 14;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(COUNT_DIV - 1);
  // ==========================================================================
  // field widths and defaults
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] BLINK_PERIOD = 16'h2710;
  localparam logic [CNT_W-1:0] BLINK_COMPARE = 16'h1388;
  // one colour step lasts one second of the counting clock
  localparam logic [CNT_W-1:0] COLOUR_PERIOD = 16'h00ff;
  localparam logic [CNT_W-1:0] HOLD_TICKS_LAST = 16'h270f;
  localparam int unsigned N_COLOURS = 7;
  localparam int unsigned N_CH = 3;
  // ==========================================================================
  // modes
  typedef enum logic {
    PLC_MODE_BLINK,
    PLC_MODE_COLOUR
  } plc_mode_t;
  // colour index order: violet indigo blue green yellow orange red
  localparam logic [2:0] COLOUR_LAST = 3'h6;
endpackage

// ===== logic/plc_top.sv
// led pulse-width modulator: blue blink mode and seven-colour cycle mode
`timescale 1ns/1ps
module plc_top (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic mode_colour_in,
  input wire logic [plc_pkg::CNT_W-1:0] blink_period_in,
  input wire logic [plc_pkg::CNT_W-1:0] blink_compare_in,
  input wire logic use_defaults_in,
  output logic red_led_drive_out,
  output logic green_led_drive_out,
  output logic blue_led_drive_out,
  output logic [2:0] colour_index_out
);
  // ==========================================================================
  // 10 kHz counting enable from the system clock
  logic [plc_pkg::DIV_W-1:0] div_q;
  wire logic tick = (div_q == plc_pkg::DIV_LAST);
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? '0 : div_q + 14'h0001; // see R4
    end
  end
  // ==========================================================================
  // mode: a change restarts channels so the new pattern begins cleanly
  plc_pkg::plc_mode_t mode_q;
  wire plc_pkg::plc_mode_t mode_sel =
    mode_colour_in ? plc_pkg::PLC_MODE_COLOUR : plc_pkg::PLC_MODE_BLINK;
  wire logic mode_chg = (mode_sel != mode_q);
  wire logic ch_reset = reset_in | mode_chg;
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      mode_q <= plc_pkg::PLC_MODE_BLINK;
    end else begin
      mode_q <= mode_sel;
    end
  end
  wire logic colour_mode = (mode_q == plc_pkg::PLC_MODE_COLOUR);
  // ==========================================================================
  // colour step timer: one second per colour
  logic [plc_pkg::CNT_W-1:0] hold_q;
  logic [2:0] colour_q;
  wire logic hold_done = tick & (hold_q == plc_pkg::HOLD_TICKS_LAST);
  always_ff @(posedge clk_sys_in) begin
    if (ch_reset) begin
      hold_q <= '0;
      colour_q <= '0;
    end else if (colour_mode && tick) begin
      hold_q <= hold_done ? '0 : hold_q + 16'h0001; // see R6
      if (hold_done) begin
        colour_q <= (colour_q == plc_pkg::COLOUR_LAST) ? 3'h0 : colour_q + 3'h1; // see R6
      end
    end
  end
  assign colour_index_out = colour_q;
  // ==========================================================================
  // colour table: compare values only, period fixed for every colour
  logic [plc_pkg::CNT_W-1:0] cmp_r;
  logic [plc_pkg::CNT_W-1:0] cmp_g;
  logic [plc_pkg::CNT_W-1:0] cmp_b;
  always_comb begin
    unique case (colour_q) // see R7
      3'h0: begin cmp_r = 16'h008f; cmp_g = 16'h0000; cmp_b = 16'h00ff; end
      3'h1: begin cmp_r = 16'h004b; cmp_g = 16'h0000; cmp_b = 16'h0082; end
      3'h2: begin cmp_r = 16'h0000; cmp_g = 16'h0000; cmp_b = 16'h0100; end
      3'h3: begin cmp_r = 16'h0000; cmp_g = 16'h0100; cmp_b = 16'h0000; end
      3'h4: begin cmp_r = 16'h0100; cmp_g = 16'h0100; cmp_b = 16'h0000; end
      3'h5: begin cmp_r = 16'h0100; cmp_g = 16'h0080; cmp_b = 16'h0000; end
      3'h6: begin cmp_r = 16'h0100; cmp_g = 16'h0000; cmp_b = 16'h0000; end
      default: begin cmp_r = 16'h0000; cmp_g = 16'h0000; cmp_b = 16'h0000; end
    endcase
  end
  // ==========================================================================
  // per-channel period and compare selection
  wire logic [plc_pkg::CNT_W-1:0] blink_per =
    use_defaults_in ? plc_pkg::BLINK_PERIOD : blink_period_in; // see R2 see R3
  wire logic [plc_pkg::CNT_W-1:0] blink_cmp =
    use_defaults_in ? plc_pkg::BLINK_COMPARE : blink_compare_in; // see R2 see R3
  logic [plc_pkg::CNT_W-1:0] per [plc_pkg::N_CH];
  logic [plc_pkg::CNT_W-1:0] cmp [plc_pkg::N_CH];
  logic [plc_pkg::N_CH-1:0] pwm;
  assign per[0] = plc_pkg::COLOUR_PERIOD;
  assign per[1] = plc_pkg::COLOUR_PERIOD;
  // blink default: period value 10000 is loaded as 9999, so 10000 ticks including wrap -> 1 Hz
  assign per[2] = colour_mode ? plc_pkg::COLOUR_PERIOD : blink_per - 16'h0001;
  assign cmp[0] = cmp_r;
  assign cmp[1] = cmp_g;
  assign cmp[2] = colour_mode ? cmp_b : blink_cmp;
  genvar i;
  generate
    for (i = 0; i < plc_pkg::N_CH; i++) begin : g_ch
      plc_channel u_ch (
        .clk_sys_in(clk_sys_in),
        .reset_in(ch_reset),
        .tick_in(tick),
        .period_in(per[i]),
        .compare_in(cmp[i]),
        .pwm_out(pwm[i])
      ); // see R5
    end
  endgenerate
  // red and green stay dark in blink mode
  assign red_led_drive_out = colour_mode & pwm[0]; // see R5
  assign green_led_drive_out = colour_mode & pwm[1]; // see R5
  assign blue_led_drive_out = pwm[2]; // see R1
endmodule
